//--- hdl/reset_source_combiner_status.sv
// reset source combiner with cause/status register behind an APB slave
// assumes sources are synchronous levels; power-on source is held by surrounding logic
// Function
// - master reset asserts while any source is active
// - nine reset sources accepted
// - each reset type sets a cause flag; illegal opcode and uninitialized W share one
// - power-on clears all cause bits except brown-out and power-on, which set
// - software may set or clear status bits; no reset results
// - brown-out or power-on reset during battery operation sets flags in battery register
// - only selected registers take defined values; others keep contents
// - trap conflict sets bit 15
// - illegal opcode or uninitialized W sets bit 14
// - bit 12 selects low-voltage retention during sleep
// - regulator config at one disables retention
// - bit 10 records deep sleep
// - configuration mismatch sets bit 9
// - bit 8 keeps flash bias powered in sleep
// - regulator re-enable adds wake delay; bias keep avoids it
// - master clear pin sets bit 7
// - software reset instruction sets bit 6
// - watchdog force config at one keeps watchdog running
// - bit 5 enables watchdog; bit 4 timeout flag, cleared by clear/power-save/power-on
// - sleep and idle instructions set bits 3 and 2
// - sleep instruction with deep sleep arm sets deep sleep flag
`timescale 1ns/100ps
`default_nettype none
module reset_source_combiner_status (
    // clock and reset
    input  wire logic                                      clk,
    input  wire logic                                      rst_n,
    // apb slave
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [7:0]                                paddr,
    input  wire logic [31:0]                               pwdata,
    output logic                                           pready,
    output logic [31:0]                                    prdata,
    output logic                                           pslverr,
    // reset sources, active high levels
    input  wire logic [reset_combiner_pkg::SRC_COUNT-1:0]  resetSource,
    input  wire logic                                      batteryActive,
    input  wire logic                                      batteryPorEvent,
    // instruction events, one-cycle pulses, and the sleep state level
    input  wire logic                                      watchdogClearInstruction,
    input  wire logic                                      sleepInstruction,
    input  wire logic                                      idleInstruction,
    input  wire logic                                      inSleep,
    // outputs to the system
    output logic                                           masterReset,
    output logic                                           watchdogRun,
    output logic                                           lowVoltHoldActive,
    output logic                                           flashBiasPowered,
    output logic                                           regulatorWakeDelay
);
    import reset_combiner_pkg::*;

    logic [15:0] cause;
    logic [15:0] next_cause;
    logic [3:0]  battery;
    logic [3:0]  next_battery;
    logic [2:0]  cfg;
    logic [2:0]  next_cfg;
    logic        next_masterReset;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_watchdogRun;
    logic        next_lowVoltHold;
    logic        next_flashBias;
    logic        next_wakeDelay;
    logic        wrCause;
    logic        wrBattery;
    logic        wrCfg;
    logic        access;
    logic        porActive;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign access    = psel && !penable;
    assign porActive = resetSource[SRC_POR];
    assign wrCause   = access && pwrite && hit(paddr, CAUSE_OFFSET);
    assign wrBattery = access && pwrite && hit(paddr, BATTERY_OFFSET);
    assign wrCfg     = access && pwrite && hit(paddr, CONFIG_OFFSET);

    // cause register: write first, hardware events afterwards so sets win
    always_comb begin
        next_cause = cause;
        if (wrCause) begin
            next_cause = pwdata[15:0] & CAUSE_MASK;
        end
        if (resetSource[SRC_TRAP]) next_cause[TRAP_BIT] = 1'b1;
        if (resetSource[SRC_OPCODE] || resetSource[SRC_UNINIT]) begin
            next_cause[OPCODE_BIT] = 1'b1;
        end
        if (resetSource[SRC_MISMATCH]) next_cause[MISMATCH_BIT] = 1'b1;
        if (resetSource[SRC_PIN]) next_cause[PIN_BIT] = 1'b1;
        if (resetSource[SRC_SOFT]) next_cause[SOFT_BIT] = 1'b1;
        if (resetSource[SRC_BROWN]) next_cause[BROWN_BIT] = 1'b1;
        // clear events for the timeout flag, then timeout so it wins
        if (watchdogClearInstruction || sleepInstruction || idleInstruction) begin
            next_cause[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end
        if (resetSource[SRC_WDT]) next_cause[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        if (sleepInstruction) begin
            next_cause[SLEEP_BIT] = 1'b1;
            if (cfg[2]) next_cause[DEEP_BIT] = 1'b1;
        end
        if (idleInstruction) next_cause[IDLE_BIT] = 1'b1;
        if (porActive) next_cause = CAUSE_RESET;
    end

    // battery flags: hardware set only, software clear only
    always_comb begin
        next_battery = battery;
        if (wrBattery) next_battery = battery & pwdata[3:0];
        if (batteryActive && (|resetSource)) begin
            next_battery[3] = next_battery[3] | resetSource[SRC_BROWN];
            next_battery[2] = next_battery[2] | porActive;
            next_battery[0] = next_battery[0] | porActive;
        end
        if (batteryPorEvent) next_battery[1] = 1'b1;
    end

    always_comb begin
        next_cfg = cfg;
        if (wrCfg) next_cfg = pwdata[2:0];
    end

    // system-facing outputs
    always_comb begin
        next_masterReset = |resetSource;
        next_watchdogRun = cfg[1] || cause[SWDT_BIT];
        next_lowVoltHold = inSleep && cause[RETAIN_BIT] && !cfg[0];
        next_flashBias   = !inSleep || cause[BIAS_BIT];
        // wake delay only when bias was dropped in sleep
        next_wakeDelay   = inSleep && !cause[BIAS_BIT];
    end

    // apb answer: zero-wait, data valid in access phase
    always_comb begin
        next_pready  = access;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (access) begin
            unique case (paddr)
                CAUSE_OFFSET:   next_prdata = {16'h0000, cause};
                BATTERY_OFFSET: next_prdata = {28'h0000000, battery};
                CONFIG_OFFSET:  next_prdata = {29'h00000000, cfg};
                STATE_OFFSET:   next_prdata = {27'h0000000, regulatorWakeDelay,
                                               flashBiasPowered, lowVoltHoldActive,
                                               watchdogRun, masterReset};
                default:        next_pslverr = 1'b1;
            endcase
        end
    end

    // the cause/battery/config registers and every registered output take reset values here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cause              <= CAUSE_RESET;
            battery            <= BATTERY_RESET;
            cfg                <= CONFIG_RESET;
            masterReset        <= 1'b1;
            watchdogRun        <= 1'b1;
            lowVoltHoldActive  <= 1'b0;
            flashBiasPowered   <= 1'b1;
            regulatorWakeDelay <= 1'b0;
            pready             <= 1'b0;
            prdata             <= 32'h0000_0000;
            pslverr            <= 1'b0;
        end else begin
            cause              <= next_cause;
            battery            <= next_battery;
            cfg                <= next_cfg;
            masterReset        <= next_masterReset;
            watchdogRun        <= next_watchdogRun;
            lowVoltHoldActive  <= next_lowVoltHold;
            flashBiasPowered   <= next_flashBias;
            regulatorWakeDelay <= next_wakeDelay;
            pready             <= next_pready;
            prdata             <= next_prdata;
            pslverr            <= next_pslverr;
        end
    end
endmodule
`default_nettype wire

//--- hdl/reset_combiner_pkg.sv
// constants for the reset source combiner and its status registers
// assumes an APB slave with 32-bit data, one aligned word per register
package reset_combiner_pkg;
    // register byte offsets
    localparam logic [7:0] CAUSE_OFFSET   = 8'h00;
    localparam logic [7:0] BATTERY_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET  = 8'h08;
    localparam logic [7:0] STATE_OFFSET   = 8'h0C;
    // cause register field positions
    localparam int TRAP_BIT     = 15;
    localparam int OPCODE_BIT   = 14;
    localparam int RETAIN_BIT   = 12;
    localparam int DEEP_BIT     = 10;
    localparam int MISMATCH_BIT = 9;
    localparam int BIAS_BIT     = 8;
    localparam int PIN_BIT      = 7;
    localparam int SOFT_BIT     = 6;
    localparam int SWDT_BIT     = 5;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT     = 4;
    localparam int SLEEP_BIT    = 3;
    localparam int IDLE_BIT     = 2;
    localparam int BROWN_BIT    = 1;
    localparam int POWER_BIT    = 0;
    // implemented bits and power-on value
    localparam logic [15:0] CAUSE_MASK  = 16'hD7FF;
    localparam logic [15:0] CAUSE_RESET = 16'h0003;
    // battery flags: brown-out, power-on, battery power-on, battery exit
    localparam logic [3:0]  BATTERY_RESET = 4'hE;
    // config register: bit0 regulator cfg, bit1 watchdog force, bit2 deep sleep arm
    localparam logic [2:0]  CONFIG_RESET = 3'h3;
    // source vector positions
    localparam int SRC_COUNT = 9;
    localparam int SRC_POR = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_SOFT = 2;
    localparam int SRC_WDT = 3;
    localparam int SRC_BROWN = 4;
    localparam int SRC_MISMATCH = 5;
    localparam int SRC_TRAP = 6;
    localparam int SRC_OPCODE = 7;
    localparam int SRC_UNINIT = 8;
endpackage

//--- bench/reset_combiner_chk.sv
// checker on the combiner ports
// assumes a bind into reset_source_combiner_status
`timescale 1ns/100ps
`default_nettype none
module reset_combiner_chk (
    // watched ports
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [8:0]  resetSource,
    input wire logic        inSleep,
    input wire logic        masterReset,
    input wire logic        lowVoltHoldActive,
    input wire logic        flashBiasPowered,
    input wire logic        regulatorWakeDelay
);
    import reset_combiner_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // skip the edge right after release: the output still holds its reset value there
    property p_mr; $past(rst_n) |-> masterReset == (|$past(resetSource)); endproperty
    a_mr: assert property (p_mr) else $error("master reset not the OR of sources");
    property p_rdy; 1 |=> pready == $past(psel && !penable); endproperty
    a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
    property p_err; psel && !penable && paddr > STATE_OFFSET |=> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access cycle");
    property p_gap; pready && !pwrite && paddr == CAUSE_OFFSET |-> (prdata & 32'hFFFF2800) == 32'h0; endproperty
    a_gap: assert property (p_gap) else $error("unimplemented cause bits read nonzero");
    property p_bias; !inSleep |=> flashBiasPowered; endproperty
    a_bias: assert property (p_bias) else $error("flash bias off while awake");
    property p_wake; regulatorWakeDelay == !flashBiasPowered; endproperty
    a_wake: assert property (p_wake) else $error("wake delay not tied to bias loss");
    property p_hold; !inSleep |=> !lowVoltHoldActive; endproperty
    a_hold: assert property (p_hold) else $error("retention active while awake");
    c_mr: cover property (resetSource != 9'h000 ##1 masterReset);
    c_err: cover property (pslverr);
    c_hold: cover property (lowVoltHoldActive);
endmodule
`default_nettype wire

//--- bench/reset_source_model.sv
// partner model: reset-source logic and instruction decode
// assumes bench requests last one cycle
`timescale 1ns/100ps
`default_nettype none
module reset_source_model (
    // requests
    input  wire logic       clk,
    input  wire logic [8:0] srcReq,
    input  wire logic [2:0] instReq,
    // toward the combiner
    output var logic [8:0]  resetSource = 9'h000,
    output var logic [2:0]  instPulse = 3'h0
);
    // sources end after one cycle, as a source does once the core is held
    always @(posedge clk) begin
        resetSource <= srcReq;
        instPulse <= instReq;
    end
endmodule
`default_nettype wire

//--- bench/reset_source_combiner_status_tb.sv
// self-checking bench for the reset combiner
// assumes package, design, checker and model compiled first
`timescale 1ns/100ps
`default_nettype none
module reset_source_combiner_status_tb;
    import reset_combiner_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, inSleep = 0, errSeen;
    logic batteryActive = 0, batteryPorEvent = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [8:0] srcReq = 9'h000, resetSource;
    logic [2:0] instReq = 3'h0, inst;
    logic pready, pslverr, masterReset, watchdogRun, lowVoltHoldActive, flashBiasPowered, regulatorWakeDelay;
    int err_count = 0, checks_done = 0;
    int flagBit[9] = '{POWER_BIT, PIN_BIT, SOFT_BIT, WATCHDOG_TIMEOUT_FLAG_BIT, BROWN_BIT, MISMATCH_BIT, TRAP_BIT, OPCODE_BIT, OPCODE_BIT};
    always #4 clk = ~clk;
    reset_source_model i_reset_source_model (.clk(clk), .srcReq(srcReq), .instReq(instReq),
        .resetSource(resetSource), .instPulse(inst));
    reset_source_combiner_status i_reset_source_combiner_status (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .resetSource(resetSource), .batteryActive(batteryActive),
        .batteryPorEvent(batteryPorEvent),
        .watchdogClearInstruction(inst[0]), .sleepInstruction(inst[1]), .idleInstruction(inst[2]),
        .inSleep(inSleep), .masterReset(masterReset), .watchdogRun(watchdogRun),
        .lowVoltHoldActive(lowVoltHoldActive), .flashBiasPowered(flashBiasPowered),
        .regulatorWakeDelay(regulatorWakeDelay));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        errSeen = pslverr;
        {psel, penable} <= 2'b00;
        // let registered outputs settle before callers look at them
        @(negedge clk);
    endtask
    // request lands in the model at the next edge, the combiner sees it one edge later
    task automatic fire(input logic [8:0] s, input logic [2:0] i);
        @(posedge clk);
        {srcReq, instReq} <= {s, i};
        @(posedge clk);
        {srcReq, instReq} <= 12'h000;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, CAUSE_OFFSET, 0);
        chk("cause at power-on", rd, 32'h3);
        apb(0, BATTERY_OFFSET, 0);
        chk("battery flags at power-on", rd, 32'hE);
        for (int k = 1; k < 9; k++) begin
            apb(1, CAUSE_OFFSET, 0);
            fire(9'h001 << k, 3'h0);
            chk("master reset", masterReset, 1);
            apb(0, CAUSE_OFFSET, 0);
            chk("cause flag", rd, 32'h1 << flagBit[k]);
        end
        apb(1, CAUSE_OFFSET, 32'hFFFF);
        chk("no reset from flag write", masterReset, 0);
        apb(0, CAUSE_OFFSET, 0);
        chk("cause all set", rd, 32'hD7FF);
        fire(9'h001, 3'h0);
        apb(0, CAUSE_OFFSET, 0);
        chk("cause after power-on source", rd, 32'h3);
        apb(0, 8'h10, 32'h0);
        chk("unmapped error", errSeen, 1);
        chk("unmapped data", rd, 0);
        apb(1, BATTERY_OFFSET, 0);
        @(posedge clk);
        {batteryActive, batteryPorEvent} <= 2'b11;
        fire(9'h011, 3'h0);
        @(posedge clk);
        {batteryActive, batteryPorEvent} <= 2'b00;
        apb(0, BATTERY_OFFSET, 0);
        chk("battery flags after reset on battery", rd, 32'hF);
        // regulator cfg zero, force off, deep sleep armed
        apb(1, CONFIG_OFFSET, 32'h4);
        apb(1, CAUSE_OFFSET, 0);
        chk("watchdog off", watchdogRun, 0);
        apb(1, CAUSE_OFFSET, 32'h20);
        chk("watchdog soft on", watchdogRun, 1);
        apb(1, CONFIG_OFFSET, 32'h6);
        apb(1, CAUSE_OFFSET, 0);
        chk("watchdog forced", watchdogRun, 1);
        fire(0, 3'h2);
        fire(0, 3'h4);
        fire(9'h008, 3'h0);
        fire(0, 3'h1);
        apb(0, CAUSE_OFFSET, 0);
        chk("sleep deep idle, timeout cleared", rd, 32'h40C);
        apb(1, CAUSE_OFFSET, 32'h1000);
        @(posedge clk);
        inSleep <= 1'b1;
        repeat (2) @(negedge clk);
        chk("retention in sleep", lowVoltHoldActive, 1);
        chk("bias off in sleep", {flashBiasPowered, regulatorWakeDelay}, 32'h1);
        apb(1, CONFIG_OFFSET, 32'h7);
        @(negedge clk);
        chk("retention blocked by cfg", lowVoltHoldActive, 0);
        apb(1, CAUSE_OFFSET, 32'h1100);
        @(negedge clk);
        chk("bias kept in sleep", {flashBiasPowered, regulatorWakeDelay}, 32'h2);
        @(posedge clk);
        inSleep <= 1'b0;
        tally_and_finish();
    end
endmodule
bind reset_source_combiner_status reset_combiner_chk i_reset_combiner_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .resetSource(resetSource), .inSleep(inSleep), .masterReset(masterReset),
    .lowVoltHoldActive(lowVoltHoldActive), .flashBiasPowered(flashBiasPowered),
    .regulatorWakeDelay(regulatorWakeDelay));
`default_nettype wire
